// ===== design/bsl_params.svh
// Constants of the boundary scan instruction logic: codes, widths, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BSL_PARAMS_SVH
`define BSL_PARAMS_SVH

`define BSL_IR_W        3
`define BSL_BSR_LEN     124
`define BSL_FIFO_DEPTH  16

`define BSL_IR_EXTEST   3'h0
`define BSL_IR_IDCODE   3'h1
`define BSL_IR_BYPASS0  3'h2
`define BSL_IR_CLAMP    3'h3
`define BSL_IR_MODULE   3'h4
`define BSL_IR_BYPASS1  3'h5
`define BSL_IR_SAMPLE   3'h6
`define BSL_IR_BYPASS2  3'h7

`define BSL_IR_RESET    3'h1
`define BSL_IR_CAPTURE  3'h1

`endif

// ===== design/bsl_pkg.sv
// Types of the boundary scan instruction logic.
// Assumes bsl_params.svh is on the include path.
`include "bsl_params.svh"

package bsl_pkg;

  typedef enum logic [3:0] {
    BSL_TLR    = 4'h0,
    BSL_RTI    = 4'h1,
    BSL_SEL_DR = 4'h3,
    BSL_CAP_DR = 4'h2,
    BSL_SH_DR  = 4'h6,
    BSL_EX1_DR = 4'h7,
    BSL_PA_DR  = 4'h5,
    BSL_EX2_DR = 4'h4,
    BSL_UPD_DR = 4'hc,
    BSL_SEL_IR = 4'hd,
    BSL_CAP_IR = 4'hf,
    BSL_SH_IR  = 4'he,
    BSL_EX1_IR = 4'ha,
    BSL_PA_IR  = 4'hb,
    BSL_EX2_IR = 4'h9,
    BSL_UPD_IR = 4'h8
  } bsl_tap_state_t;

  typedef struct packed {
    logic sel_bsr;
    logic ext_ctl;
    logic sys_rst;
  } bsl_mode_t;

  function automatic bsl_mode_t bsl_decode(input logic [`BSL_IR_W-1:0] ir);
    bsl_mode_t m;
    m = '{sel_bsr: 1'b0, ext_ctl: 1'b0, sys_rst: 1'b0};
    case (ir)
      `BSL_IR_EXTEST: m = '{sel_bsr: 1'b1, ext_ctl: 1'b1, sys_rst: 1'b1};
      `BSL_IR_SAMPLE: m = '{sel_bsr: 1'b1, ext_ctl: 1'b0, sys_rst: 1'b0};
      `BSL_IR_CLAMP:  m = '{sel_bsr: 1'b0, ext_ctl: 1'b1, sys_rst: 1'b0};
      default:        m = '{sel_bsr: 1'b0, ext_ctl: 1'b0, sys_rst: 1'b0};
    endcase
    return m;
  endfunction

endpackage

// ===== design/bsl_sync.sv
// Two-stage synchroniser for levels and toggles entering a clock domain.
// Assumes the input is stable or changes one bit at a time per event.
`timescale 1ns/1ps
`default_nettype none

module bsl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // bsl_sync

`default_nettype wire

// ===== design/bsl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on clk_i; storage is a register array.
`timescale 1ns/1ps
`default_nettype none

module bsl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    in_ready_o  = (cnt_q != FULL_CNT);
    out_valid_o = (cnt_q != '0);
    out_data_o  = mem_q[rd_q];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_d        = push ? ((wr_q == LAST_PTR) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d        = pop ? ((rd_q == LAST_PTR) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d       = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule // bsl_fifo

`default_nettype wire

// ===== design/bsl_top.sv
// Boundary scan instruction logic: TAP controller, instruction register,
// bypass and boundary registers on TCK, pin multiplexer on the system clock.
// Assumes the tester drives tck_i, tms_i, tdi_i, trst_n_i; the pad ring
// resolves tdo and the pin cells from the levels and enables given here.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_params.svh"

module bsl_top
  import bsl_pkg::*;
#(
  parameter int BSR_LEN    = `BSL_BSR_LEN,
  parameter int FIFO_DEPTH = `BSL_FIFO_DEPTH
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               tck_i,
  input  wire logic               trst_n_i,
  input  wire logic               tms_i,
  input  wire logic               tdi_i,
  output var  logic               tdo_o,
  output var  logic               tdo_oe_o,
  input  wire logic [BSR_LEN-1:0] pin_in_i,
  input  wire logic [BSR_LEN-1:0] sys_val_i,
  input  wire logic               pin_hold_i,
  output var  logic [BSR_LEN-1:0] pin_val_o,
  output var  logic               sys_reset_o,
  output var  logic               test_ctl_o
);

  // ---------------- Link domain (TCK) ----------------
  logic                  tap_rst;
  bsl_tap_state_t        st_q, st_d;
  logic [`BSL_IR_W-1:0]  ir_sh_q, ir_sh_d;
  logic [`BSL_IR_W-1:0]  ir_q, ir_d;
  logic [BSR_LEN-1:0]    bsr_sh_q, bsr_sh_d;
  logic [BSR_LEN-1:0]    bsr_upd_q, bsr_upd_d;
  logic [BSR_LEN-1:0]    xfer_q, xfer_d;
  logic [BSR_LEN-1:0]    pin_s;
  logic                  byp_q, byp_d;
  logic                  dirty_q, dirty_d;
  logic                  req_q, req_d;
  logic                  ack_s;
  logic                  ack_q, ack_d;
  bsl_mode_t             mode_q, mode_d, cur;
  logic                  tdo_d, tdo_oe_d;

  assign tap_rst = rst_i | ~trst_n_i;

  bsl_sync #(.WIDTH(BSR_LEN)) u_pin_sync (
    .clk_i (tck_i),
    .rst_i (tap_rst),
    .d_i   (pin_in_i),
    .q_o   (pin_s)
  );

  bsl_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i (tck_i),
    .rst_i (tap_rst),
    .d_i   (ack_q),
    .q_o   (ack_s)
  );

  // TAP state sequence
  always_comb begin
    case (st_q)
      BSL_TLR:    st_d = tms_i ? BSL_TLR : BSL_RTI;
      BSL_RTI:    st_d = tms_i ? BSL_SEL_DR : BSL_RTI;
      BSL_SEL_DR: st_d = tms_i ? BSL_SEL_IR : BSL_CAP_DR;
      BSL_CAP_DR: st_d = tms_i ? BSL_EX1_DR : BSL_SH_DR;
      BSL_SH_DR:  st_d = tms_i ? BSL_EX1_DR : BSL_SH_DR;
      BSL_EX1_DR: st_d = tms_i ? BSL_UPD_DR : BSL_PA_DR;
      BSL_PA_DR:  st_d = tms_i ? BSL_EX2_DR : BSL_PA_DR;
      BSL_EX2_DR: st_d = tms_i ? BSL_UPD_DR : BSL_SH_DR;
      BSL_UPD_DR: st_d = tms_i ? BSL_SEL_DR : BSL_RTI;
      BSL_SEL_IR: st_d = tms_i ? BSL_TLR : BSL_CAP_IR;
      BSL_CAP_IR: st_d = tms_i ? BSL_EX1_IR : BSL_SH_IR;
      BSL_SH_IR:  st_d = tms_i ? BSL_EX1_IR : BSL_SH_IR;
      BSL_EX1_IR: st_d = tms_i ? BSL_UPD_IR : BSL_PA_IR;
      BSL_PA_IR:  st_d = tms_i ? BSL_EX2_IR : BSL_PA_IR;
      BSL_EX2_IR: st_d = tms_i ? BSL_UPD_IR : BSL_SH_IR;
      BSL_UPD_IR: st_d = tms_i ? BSL_SEL_DR : BSL_RTI;
      default:    st_d = BSL_TLR;
    endcase
  end

  always_ff @(posedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      st_q <= BSL_TLR;
    end else begin
      st_q <= st_d;
    end
  end

  // Decoded active instruction
  assign cur = bsl_decode(ir_q);

  // Instruction register: shift stages and parallel outputs
  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    case (st_q)
      BSL_TLR: begin
        ir_d = `BSL_IR_RESET;
      end
      BSL_CAP_IR: begin
        ir_sh_d = `BSL_IR_CAPTURE;
      end
      BSL_SH_IR: begin
        ir_sh_d = {tdi_i, ir_sh_q[`BSL_IR_W-1:1]};
      end
      BSL_UPD_IR: begin
        ir_d = ir_sh_q;
      end
      default: begin
      end
    endcase
    // Mode follows the new instruction at once, as TCK may stop after it
    mode_d = bsl_decode(ir_d);
  end

  always_ff @(posedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sh_q <= `BSL_IR_CAPTURE;
      ir_q    <= `BSL_IR_RESET;
      mode_q  <= '{sel_bsr: 1'b0, ext_ctl: 1'b0, sys_rst: 1'b0};
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
      mode_q  <= mode_d;
    end
  end

  // Bypass stage and boundary shift stages
  always_comb begin
    bsr_sh_d = bsr_sh_q;
    byp_d    = byp_q;
    case (st_q)
      BSL_CAP_DR: begin
        if (cur.sel_bsr) begin
          bsr_sh_d = pin_s;
        end else begin
          byp_d = 1'b0;
        end
      end
      BSL_SH_DR: begin
        if (cur.sel_bsr) begin
          bsr_sh_d = {tdi_i, bsr_sh_q[BSR_LEN-1:1]};
        end else begin
          byp_d = tdi_i;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      bsr_sh_q <= '0;
      byp_q    <= 1'b0;
    end else begin
      bsr_sh_q <= bsr_sh_d;
      byp_q    <= byp_d;
    end
  end

  // Hand-over of updated boundary words to the system clock side
  always_comb begin
    bsr_upd_d = bsr_upd_q;
    xfer_d    = xfer_q;
    req_d     = req_q;
    dirty_d   = dirty_q;
    if ((st_q == BSL_UPD_DR) && cur.sel_bsr) begin
      bsr_upd_d = bsr_sh_q;
      if (req_q == ack_s) begin
        // Sent at once, so a stopped TCK cannot strand the word
        xfer_d  = bsr_sh_q;
        req_d   = ~req_q;
        dirty_d = 1'b0;
      end else begin
        // Newest word waits; the set wins over a clear
        dirty_d = 1'b1;
      end
    end else if (dirty_q && (req_q == ack_s)) begin
      xfer_d  = bsr_upd_q;
      req_d   = ~req_q;
      dirty_d = 1'b0;
    end
  end

  always_ff @(posedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      bsr_upd_q <= '0;
      xfer_q    <= '0;
      dirty_q   <= 1'b0;
      req_q     <= 1'b0;
    end else begin
      bsr_upd_q <= bsr_upd_d;
      xfer_q    <= xfer_d;
      dirty_q   <= dirty_d;
      req_q     <= req_d;
    end
  end

  // TDO changes on the falling edge, driven only while shifting
  always_comb begin
    tdo_d    = tdo_o;
    tdo_oe_d = 1'b0;
    if (st_q == BSL_SH_IR) begin
      tdo_d    = ir_sh_q[0];
      tdo_oe_d = 1'b1;
    end else if (st_q == BSL_SH_DR) begin
      tdo_d    = cur.sel_bsr ? bsr_sh_q[0] : byp_q;
      tdo_oe_d = 1'b1;
    end
  end

  always_ff @(negedge tck_i or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o    <= tdo_d;
      tdo_oe_o <= tdo_oe_d;
    end
  end

  // ---------------- System domain (clk_i) ----------------
  logic               req_s;
  logic [1:0]         mode_s;
  logic               in_valid, in_ready;
  logic               out_valid, out_ready;
  logic [BSR_LEN-1:0] out_data;
  logic [BSR_LEN-1:0] bnd_q, bnd_d;
  logic [BSR_LEN-1:0] pin_val_d;
  logic               sys_reset_d, test_ctl_d;

  bsl_sync #(.WIDTH(1)) u_req_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (req_q),
    .q_o   (req_s)
  );

  bsl_sync #(.WIDTH(2)) u_mode_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({mode_q.ext_ctl, mode_q.sys_rst}),
    .q_o   (mode_s)
  );

  bsl_fifo #(.WIDTH(BSR_LEN), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (xfer_q),
    .out_valid_o (out_valid),
    .out_ready_i (out_ready),
    .out_data_o  (out_data)
  );

  // Pin multiplexer, one cell per bit
  for (genvar g = 0; g < BSR_LEN; g++) begin : g_pin_mux
    assign pin_val_d[g] = mode_s[1] ? bnd_q[g] : sys_val_i[g];
  end

  always_comb begin
    in_valid    = (req_s != ack_q);
    ack_d       = (in_valid && in_ready) ? ~ack_q : ack_q;
    out_ready   = ~pin_hold_i;
    bnd_d       = (out_valid && out_ready) ? out_data : bnd_q;
    sys_reset_d = mode_s[0];
    test_ctl_d  = mode_s[1];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q       <= 1'b0;
      bnd_q       <= '0;
      pin_val_o   <= '0;
      sys_reset_o <= 1'b0;
      test_ctl_o  <= 1'b0;
    end else begin
      ack_q       <= ack_d;
      bnd_q       <= bnd_d;
      pin_val_o   <= pin_val_d;
      sys_reset_o <= sys_reset_d;
      test_ctl_o  <= test_ctl_d;
    end
  end

endmodule // bsl_top

`default_nettype wire

// ===== testbench/bsl_tap_host.sv
// Test controller model driving the TAP; tck stands still between scans.
// Assumes tdo_i is only read on rising tck while shifting.
`timescale 1ns/1ps
`default_nettype none
module bsl_tap_host (
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic trst_n_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1; // Idle high like a pull-up
    tdi_o    = 1'b1;
    trst_n_o = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    #62.5 tck_o = 1'b1;
    o = tdo_i;
    #62.5 tck_o = 1'b0;
  endtask
  task automatic idle_reset();
    logic o;
    repeat (8) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  task automatic trst_pulse();
    trst_n_o = 1'b0;
    #200 trst_n_o = 1'b1;
  endtask
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~din[n-1], o);
    step(1'b0, din[n-1], o);
  endtask
endmodule // bsl_tap_host
`default_nettype wire

// ===== testbench/bsl_top_asserts.sv
// Checker of the boundary scan instruction logic ports.
// Assumes binding to bsl_top.
`timescale 1ns/1ps
`default_nettype none
module bsl_top_asserts #(parameter int BSR_LEN = 124) (
  input wire logic clk_i, rst_i, tck_i, trst_n_i, tms_i, tdi_i,
  input wire logic tdo_o, tdo_oe_o, pin_hold_i, sys_reset_o, test_ctl_o,
  input wire logic [BSR_LEN-1:0] pin_in_i, sys_val_i, pin_val_o
);
  property p_ext_rst;
    @(posedge clk_i) disable iff (rst_i) sys_reset_o |-> test_ctl_o;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("reset without pin control");
  property p_sys_pass;
    @(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) && !$past(test_ctl_o) && !test_ctl_o |-> pin_val_o == $past(sys_val_i);
  endproperty
  a_sys_pass: assert property (p_sys_pass) else $error("pins not functional");
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (test_ctl_o && pin_hold_i) [*4] |-> $stable(pin_val_o);
  endproperty
  a_hold: assert property (p_hold) else $error("pins moved under hold");
  property p_tlr5;
    @(posedge tck_i) disable iff (rst_i || !trst_n_i) tms_i [*5] |=> !tdo_oe_o;
  endproperty
  a_tlr5: assert property (p_tlr5) else $error("tdo driven after reset walk");
  property p_tlr8;
    @(posedge tck_i) disable iff (rst_i || !trst_n_i) tms_i [*8] |-> !test_ctl_o;
  endproperty
  a_tlr8: assert property (p_tlr8) else $error("test mode kept in reset");
  property p_trst;
    @(posedge clk_i) disable iff (rst_i) !trst_n_i |-> !tdo_oe_o ##4 !test_ctl_o;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_oe_rise;
    @(posedge tck_i) disable iff (rst_i || !trst_n_i) $rose(tdo_oe_o) |-> !$past(tms_i);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("shift entered wrongly");
  property p_oe_fall;
    @(posedge tck_i) disable iff (rst_i || !trst_n_i) $fell(tdo_oe_o) |-> $past(tms_i);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("shift left wrongly");
  c_ext: cover property (@(posedge clk_i) $rose(sys_reset_o));
  c_clamp: cover property (@(posedge clk_i) test_ctl_o && !sys_reset_o);
  c_shift: cover property (@(posedge tck_i) $rose(tdo_oe_o));
endmodule // bsl_top_asserts
bind bsl_top bsl_top_asserts #(.BSR_LEN(BSR_LEN)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .tck_i(tck_i), .trst_n_i(trst_n_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o), .pin_hold_i(pin_hold_i), .sys_reset_o(sys_reset_o),
  .test_ctl_o(test_ctl_o), .pin_in_i(pin_in_i), .sys_val_i(sys_val_i),
  .pin_val_o(pin_val_o));
`default_nettype wire

// ===== testbench/boundary_scan_instruction_logic_test.sv
// Self-checking bench of bsl_top against a queue-based model.
// Assumes bsl_tap_host as tester and the checker bound.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_params.svh"
module boundary_scan_instruction_logic_test;
  import bsl_pkg::*;
  localparam int L = `BSL_BSR_LEN;
  logic clk_i, rst_i, pin_hold_i, tck, tms, tdi, trst_n, tdo, oe, sr, tc;
  logic [L-1:0] pin_in_i, sys_val_i, pin_val_o, w;
  logic [127:0] din, dout;
  logic [L-1:0] word_q[$];
  logic [2:0] codes[5] = '{3'h2, 3'h5, 3'h7, 3'h1, 3'h4};
  int err_count, checked;
  bsl_top #(.FIFO_DEPTH(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck),
    .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe),
    .pin_in_i(pin_in_i), .sys_val_i(sys_val_i), .pin_hold_i(pin_hold_i),
    .pin_val_o(pin_val_o), .sys_reset_o(sr), .test_ctl_o(tc));
  bsl_tap_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo));
  function automatic logic [L-1:0] rnd();
    logic [127:0] r;
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    return r[L-1:0];
  endfunction
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ir(input logic [2:0] c);
    host.scan(1'b1, 3, {125'h0, c}, dout);
    repeat (6) @(posedge clk_i);
  endtask
  task automatic modes(input logic s, input logic t);
    chk(sr === s && tc === t, "mode outputs");
  endtask
  task automatic wait_pins(input logic [L-1:0] x);
    for (int k = 0; k < 60 && pin_val_o !== x; k++) @(posedge clk_i);
    chk(pin_val_o === x, "pin values");
  endtask
  task automatic byp();
    din = {rnd(), 4'h5};
    host.scan(1'b0, 8, din, dout);
    chk(dout[7:0] === {din[6:0], 1'b0}, "bypass path");
  endtask
  task automatic bsr();
    din = {rnd(), 4'h9};
    word_q.push_back(din[127:4]);
    host.scan(1'b0, L + 4, din, dout);
    chk(dout[L-1:0] === pin_in_i && dout[127:L] === din[3:0], "capture");
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) sys_val_i <= #1 rnd();
  initial begin
    #3ms chk(1'b0, "timeout");
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    pin_hold_i = 1'b0;
    pin_in_i = '0;
    err_count = 0;
    checked = 0;
    void'($urandom(9852));
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    host.idle_reset();
    repeat (6) @(posedge clk_i);
    modes(1'b0, 1'b0);
    ir(3'h2);
    chk(dout[2:0] === 3'h1, "ir capture");
    foreach (codes[i]) begin
      ir(codes[i]);
      byp();
      modes(1'b0, 1'b0);
    end
    $display("bypass test done");
    #1 pin_in_i = rnd();
    ir(`BSL_IR_SAMPLE);
    bsr();
    modes(1'b0, 1'b0);
    $display("sample test done");
    ir(`BSL_IR_EXTEST);
    modes(1'b1, 1'b1);
    wait_pins(word_q[$]);
    bsr();
    wait_pins(word_q[$]);
    w = word_q[$];
    @(posedge clk_i) #1 pin_hold_i = 1'b1;
    repeat (3) bsr();
    chk(pin_val_o === w, "held pins");
    @(posedge clk_i) #1 pin_hold_i = 1'b0;
    wait_pins(word_q[$]);
    $display("extest test done");
    ir(`BSL_IR_CLAMP);
    modes(1'b0, 1'b1);
    chk(pin_val_o === word_q[$], "clamp pins");
    byp();
    $display("clamp test done");
    host.trst_pulse();
    repeat (6) @(posedge clk_i);
    modes(1'b0, 1'b0);
    host.idle_reset();
    ir(`BSL_IR_EXTEST);
    modes(1'b1, 1'b1);
    host.idle_reset();
    repeat (6) @(posedge clk_i);
    modes(1'b0, 1'b0);
    $display("reset test done");
    final_report();
  end
endmodule // boundary_scan_instruction_logic_test
`default_nettype wire
